// ==== rtl/spi_ee_pkg.sv ====
// Package: constants shared by both ends of the EEPROM access link.
// Assumes a 100 MHz system clock on both ends.
package spi_ee_pkg;
    localparam int CLK_MHZ          = 100;
    localparam int FRAME_BITS       = 48;
    localparam int FRAME_BYTES      = 6;
    localparam int WORD_BITS        = 32;
    localparam int CMD_WR_BIT       = 7;
    localparam int CMD_RD_BIT       = 6;
    localparam int CMD_ER_BIT       = 5;
    localparam int CMD_BWR_BIT      = 4;
    localparam int CMD_BER_BIT      = 3;
    localparam int CMD_TEST_BIT     = 2;
    localparam int CMD_AREA_BIT     = 0;
    // Timing, in their printed units, and derived cycle counts.
    localparam int T_EN_US          = 150;
    localparam int T_ST_US          = 2;
    localparam int T_RD_WAIT_US     = 30;
    localparam int T_WRITE_MS       = 12;
    localparam int EN_CYC           = T_EN_US * CLK_MHZ;
    localparam int ST_CYC           = T_ST_US * CLK_MHZ;
    localparam int RD_WAIT_CYC      = T_RD_WAIT_US * CLK_MHZ;
    localparam int WRITE_CYC        = T_WRITE_MS * 1000 * CLK_MHZ;
    localparam int READ_CYC         = 16;
    localparam int SCLK_HALF_CYC    = 8;
endpackage

// ==== rtl/spi_ee_if.sv ====
// Interface: enable, shift clock and two data lines between master and device.
// Assumes both ends run on one system clock; the link clock is sampled.
`timescale 1ns/1ps
`default_nettype none
interface spi_ee_if;
    logic en;
    logic sclk;
    logic din;
    logic dout;
    modport master (output en, output sclk, output din, input dout);
    modport device (input en, input sclk, input din, output dout);
endinterface
`default_nettype wire

// ==== rtl/sync2.sv ====
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/spi_ee_device.sv ====
// Function
// R1: Sample serial input on falling clock edge.
// R2: Change serial output on falling clock edge.
// R3: Bytes travel most significant bit first.
// R4: Frame is command, address, four data bytes.
// R5: Command bits select one operation each.
// R6: Command bit 0 picks system or user area.
// R7: Address is word address; data is word.
// R8: Non-six-byte frame raises communication error; a frame cut short by enable ends with no error here.
// R9: Execute pulse 49 starts the command.
// R10: Read waits 30 us, then 33 pulses.
// R11: Last 32 extra pulses carry the word.
// R12: Write done raises output after memory write.
// R13: Read ready raises output; acknowledge pulse follows.
// R14: A read uses 82 clock pulses.
// R15: Master waits 150 us before first edge.
// R16: Enable held 2 us after last edge.
// R17: Early enable fall discards the frame.
// Device end: shift register, command decode and a memory request port.
// Assumes an external memory that answers mem_done after a request.
`timescale 1ns/1ps
`default_nettype none
module spi_ee_device
    import spi_ee_pkg::*;
(
    // Link
    spi_ee_if.device   LINK,
    // System
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Memory side
    output logic             MEM_REQ,
    output logic [7:0]       MEM_CMD,
    output logic [7:0]       MEM_ADDR,
    output logic [31:0]      MEM_WDATA,
    input  wire logic        MEM_DONE,
    input  wire logic [31:0] MEM_RDATA,
    // Status
    output logic             COMM_ERR
);
    import spi_ee_pkg::*;

    // States follow one Gray path, so each ordinary step flips a single bit.
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_SHIFT = 3'b001,
        S_BUSY  = 3'b011,
        S_ACK   = 3'b010,
        S_DATA  = 3'b110,
        S_DONE  = 3'b111
    } state_t;

    // Link pins come from another clock domain; each passes two flip-flops first.
    logic en_s;
    logic sclk_s;
    logic din_s;

    sync2 u_en (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (LINK.en),
        .q     (en_s)
    );

    sync2 u_sclk (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (LINK.sclk),
        .q     (sclk_s)
    );

    sync2 u_din (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .d     (LINK.din),
        .q     (din_s)
    );

    state_t      state_r;
    state_t      state_nxt;
    logic        sclk_d_r;
    logic        din_d_r;
    logic [6:0]  cnt_r;
    logic [6:0]  cnt_nxt;
    logic [47:0] sh_r;
    logic [47:0] sh_nxt;
    logic [31:0] rd_r;
    logic [31:0] rd_nxt;
    logic        dout_r;
    logic        dout_nxt;
    logic        req_r;
    logic        req_nxt;
    logic        err_r;
    logic        err_nxt;

    // Edge and count decode.
    wire logic fall      = sclk_d_r & ~sclk_s;
    wire logic frame_ok  = (cnt_r == 7'(FRAME_BITS));
    wire logic more_bits = (cnt_r < 7'(FRAME_BITS));
    wire logic last_bit  = (cnt_r == 7'(WORD_BITS));

    // Command decode: one bit per operation.
    wire logic op_write  = sh_r[40 + CMD_WR_BIT]; // R5
    wire logic op_read   = sh_r[40 + CMD_RD_BIT]; // R5
    wire logic op_erase  = sh_r[40 + CMD_ER_BIT]; // R5
    wire logic op_bwrite = sh_r[40 + CMD_BWR_BIT]; // R5
    wire logic op_berase = sh_r[40 + CMD_BER_BIT]; // R5
    wire logic op_test   = sh_r[40 + CMD_TEST_BIT]; // R5
    wire logic any_op    = op_write | op_read | op_erase | op_bwrite | op_berase | op_test;

    assign LINK.dout = dout_r;
    assign MEM_REQ   = req_r;
    assign MEM_CMD   = sh_r[47:40]; // R5 R6
    assign MEM_ADDR  = sh_r[39:32]; // R7
    assign MEM_WDATA = sh_r[31:0]; // R7
    assign COMM_ERR  = err_r;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sclk_d_r <= 1'b0;
            din_d_r  <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            // Taking the bit that stood before the fall lets data move on that same fall.
            din_d_r  <= din_s;
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        rd_nxt    = rd_r;
        dout_nxt  = dout_r;
        req_nxt   = 1'b0;
        err_nxt   = err_r;
        if (!en_s) begin
            // A frame cut short by enable is dropped with no memory operation.
            state_nxt = S_IDLE; // R17
            cnt_nxt   = 7'h00; // R17
            dout_nxt  = 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    state_nxt = S_SHIFT;
                    err_nxt   = 1'b0;
                end
                S_SHIFT: begin
                    if (fall && more_bits) begin
                        sh_nxt  = {sh_r[46:0], din_d_r}; // R1 R3 R4 R7
                        cnt_nxt = cnt_r + 7'h01;
                    end else if (fall && frame_ok && any_op) begin
                        req_nxt   = 1'b1; // R9
                        state_nxt = S_BUSY;
                    end else if (fall) begin
                        err_nxt = 1'b1; // R8
                    end
                end
                S_BUSY: begin
                    if (fall) begin
                        // No pulse is due before completion, so one here means too many bytes.
                        err_nxt = 1'b1; // R8
                    end
                    if (MEM_DONE) begin
                        rd_nxt    = MEM_RDATA;
                        state_nxt = op_read ? S_ACK : S_DONE; // R12 R13
                    end
                end
                S_ACK: begin
                    if (fall && dout_r) begin
                        // Acknowledge pulse seen; the first data bit goes out on its fall.
                        dout_nxt  = rd_r[31]; // R2 R11
                        rd_nxt    = {rd_r[30:0], 1'b0};
                        cnt_nxt   = 7'h01;
                        state_nxt = S_DATA; // R13
                    end else if (!fall) begin
                        dout_nxt = 1'b1; // R13
                    end
                end
                S_DATA: begin
                    if (fall && last_bit) begin
                        state_nxt = S_DONE; // R14
                        dout_nxt  = 1'b0;
                    end else if (fall) begin
                        dout_nxt = rd_r[31]; // R2 R11
                        rd_nxt   = {rd_r[30:0], 1'b0};
                        cnt_nxt  = cnt_r + 7'h01;
                    end
                end
                S_DONE: begin
                    // Write completion stands until enable falls.
                    dout_nxt = !op_read; // R12
                    if (fall) begin
                        err_nxt = 1'b1; // R8
                    end
                end
                default: state_nxt = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state_r <= S_IDLE;
            cnt_r   <= 7'h00;
            sh_r    <= 48'h0000_0000_0000;
            rd_r    <= 32'h0000_0000;
            dout_r  <= 1'b0;
            req_r   <= 1'b0;
            err_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            rd_r    <= rd_nxt;
            dout_r  <= dout_nxt;
            req_r   <= req_nxt;
            err_r   <= err_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/spi_ee_master.sv ====
// Master end: frames a command, waits, and collects read data.
// Assumes the device end on the same system clock.
`timescale 1ns/1ps
`default_nettype none
module spi_ee_master
    import spi_ee_pkg::*;
#(
    parameter int EN_WAIT  = EN_CYC,
    parameter int RD_WAIT  = RD_WAIT_CYC,
    parameter int HALF     = SCLK_HALF_CYC
) (
    // System
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // User
    input  wire logic        START,
    input  wire logic [7:0]  CMD,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    output logic             BUSY,
    output logic             DONE,
    output logic [31:0]      RDATA,
    // Link
    spi_ee_if.master         LINK
);
    import spi_ee_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000, M_EN = 3'b001, M_SEND = 3'b011, M_WAIT = 3'b010,
        M_READ = 3'b110, M_HOLD = 3'b111
    } mstate_t;

    logic dout_s;
    sync2 u_dout (.clk(CLK_SYS), .rst_n(RST_N), .d(LINK.dout), .q(dout_s));

    mstate_t     st_r;
    logic [31:0] tmr_r;
    logic [6:0]  pulses_r;
    logic [47:0] sh_r;
    logic [31:0] rd_r;
    logic        en_r;
    logic        sclk_r;
    logic        done_r;
    logic        rd_op_r;

    wire tick     = (tmr_r == 32'h0000_0000);
    wire logic [6:0] need = rd_op_r ? 7'(FRAME_BITS + 2 + WORD_BITS) : 7'(FRAME_BITS + 1);

    assign LINK.en   = en_r;
    assign LINK.sclk = sclk_r;
    assign LINK.din  = sh_r[47]; // R3
    assign BUSY      = (st_r != M_IDLE);
    assign DONE      = done_r;
    assign RDATA     = rd_r;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_r     <= M_IDLE;
            tmr_r    <= 32'h0000_0000;
            pulses_r <= 7'h00;
            sh_r     <= 48'h0000_0000_0000;
            rd_r     <= 32'h0000_0000;
            en_r     <= 1'b0;
            sclk_r   <= 1'b0;
            done_r   <= 1'b0;
            rd_op_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (!tick) begin
                tmr_r <= tmr_r - 32'h0000_0001;
            end
            case (st_r)
                M_IDLE: begin
                    if (START) begin
                        sh_r     <= {CMD, ADDR, WDATA}; // R4
                        rd_op_r  <= CMD[CMD_RD_BIT];
                        en_r     <= 1'b1;
                        pulses_r <= 7'h00;
                        tmr_r    <= 32'(EN_WAIT); // R15
                        st_r     <= M_EN;
                    end
                end
                M_EN: if (tick) begin
                    st_r <= M_SEND;
                end
                M_SEND: if (tick) begin
                    tmr_r  <= 32'(HALF);
                    sclk_r <= ~sclk_r;
                    if (sclk_r) begin
                        // Falling edge: device samples; next bit follows.
                        pulses_r <= pulses_r + 7'h01;
                        if (pulses_r < 7'(FRAME_BITS)) begin
                            sh_r <= {sh_r[46:0], 1'b0};
                        end
                        if (pulses_r + 7'h01 == 7'(FRAME_BITS + 1)) begin
                            st_r  <= M_WAIT; // R9
                            tmr_r <= rd_op_r ? 32'(RD_WAIT) : 32'h0000_0000; // R10
                        end
                    end
                end
                M_WAIT: if (tick && dout_s) begin
                    st_r  <= rd_op_r ? M_READ : M_HOLD; // R12 R13
                    tmr_r <= rd_op_r ? 32'(HALF) : 32'(ST_CYC);
                end
                M_READ: if (tick) begin
                    tmr_r  <= 32'(HALF);
                    sclk_r <= ~sclk_r;
                    if (!sclk_r && pulses_r > 7'(FRAME_BITS + 1)) begin
                        rd_r <= {rd_r[30:0], dout_s}; // R11 R3
                    end
                    if (sclk_r) begin
                        pulses_r <= pulses_r + 7'h01;
                        if (pulses_r + 7'h01 == need) begin
                            st_r  <= M_HOLD; // R14
                            tmr_r <= 32'(ST_CYC); // R16
                        end
                    end
                end
                M_HOLD: if (tick) begin
                    en_r   <= 1'b0; // R16
                    done_r <= 1'b1;
                    st_r   <= M_IDLE;
                end
                default: st_r <= M_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verif/spi_ee_asserts.sv ====
// Checker: timing and framing properties of the link between the two ends.
// Assumes both ends run on CLK_SYS and idle the shift clock low.
`timescale 1ns/1ps
`default_nettype none
module spi_ee_asserts
    import spi_ee_pkg::*;
#(
    parameter int EN_WAIT = EN_CYC,
    parameter int RD_WAIT = RD_WAIT_CYC
) (
    // System
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Link
    input wire logic en,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout
);
    import spi_ee_pkg::*;
    logic             sclk_r;
    logic [6:0]       pulses_r;
    logic [15:0]      t_en_r;
    logic [15:0]      t_fall_r;
    // Time counters saturate so a long idle stretch never wraps into a short one.
    wire logic        rise_w     = sclk & ~sclk_r;
    wire logic        fall_w     = ~sclk & sclk_r;
    wire logic [6:0]  pulses_nxt = en ? pulses_r + 7'(rise_w) : 7'h00;
    wire logic [15:0] t_en_nxt   = en ? t_en_r + 16'(t_en_r != 16'hFFFF) : 16'h0000;
    wire logic [15:0] t_fall_nxt = fall_w ? 16'h0000 : t_fall_r + 16'(t_fall_r != 16'hFFFF);
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sclk_r   <= 1'b0;
            pulses_r <= 7'h00;
            t_en_r   <= 16'h0000;
            t_fall_r <= 16'h0000;
        end else begin
            sclk_r   <= sclk;
            pulses_r <= pulses_nxt;
            t_en_r   <= t_en_nxt;
            t_fall_r <= t_fall_nxt;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_din_hold_high: assert property (sclk && $past(sclk) |-> $stable(din))
        else $error("din moved while the shift clock was high");
    a_dout_hold_high: assert property (en && sclk && $past(sclk) |-> $stable(dout))
        else $error("dout moved while the shift clock was high");
    a_clk_idle_low: assert property (!en |-> !sclk)
        else $error("shift clock active outside enable");
    a_settle_wait: assert property ($rose(sclk) && pulses_r == 0 |-> t_en_r >= EN_WAIT - 1)
        else $error("first clock edge too soon after enable");
    a_tail_hold: assert property ($fell(en) |-> t_fall_r >= ST_CYC - 1)
        else $error("enable dropped too soon after last edge");
    a_pulse_total: assert property ($fell(en) |-> pulses_r == 49 || pulses_r == 82)
        else $error("frame pulse count is neither 49 nor 82");
    a_ack_ready: assert property ($rose(sclk) && pulses_r == 49 |-> dout)
        else $error("acknowledge pulse before data ready");
    a_read_gap: assert property ($rose(sclk) && pulses_r == 49 |-> t_fall_r >= RD_WAIT - 1)
        else $error("read pulses started too soon");
    a_write_irq: assert property ($fell(en) && pulses_r == 49 |-> dout)
        else $error("frame closed without completion");
    c_write_frame: cover property ($fell(en) && pulses_r == 49);
    c_read_frame: cover property ($fell(en) && pulses_r == 82);
    c_ack_pulse: cover property ($rose(sclk) && pulses_r == 49);
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Testbench: master and device on one link, plus a second device driven by hand.
// Assumes a memory model here answers every request of the first device after 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spi_ee_pkg::*;
    logic        clk_sys, rst_n, start, done, mem_req, mem_done, comm_err, mem_req2, comm_err2;
    logic        sclk_q, busy;
    logic [7:0]  cmd, addr, mem_cmd, mem_addr;
    logic [6:0]  n_rise;
    logic [31:0] wdata, rdata, mem_wdata, mem_rdata, rd_word;
    logic [47:0] wire_frame;
    int          n_req, n_req2, early, n_mismatch, n_checks;
    spi_ee_if link ();
    spi_ee_if link2 ();
    spi_ee_master #(.EN_WAIT(20), .RD_WAIT(10)) spi_ee_master_inst (.CLK_SYS(clk_sys),
        .RST_N(rst_n), .START(start), .CMD(cmd), .ADDR(addr), .WDATA(wdata), .BUSY(busy),
        .DONE(done), .RDATA(rdata), .LINK(link));
    spi_ee_device spi_ee_device_inst (.LINK(link), .CLK_SYS(clk_sys), .RST_N(rst_n),
        .MEM_REQ(mem_req), .MEM_CMD(mem_cmd), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .MEM_DONE(mem_done), .MEM_RDATA(mem_rdata), .COMM_ERR(comm_err));
    spi_ee_device spi_ee_device_inst2 (.LINK(link2), .CLK_SYS(clk_sys), .RST_N(rst_n),
        .MEM_REQ(mem_req2), .MEM_CMD(), .MEM_ADDR(), .MEM_WDATA(), .MEM_DONE(1'b0),
        .MEM_RDATA(32'h0000_0000), .COMM_ERR(comm_err2));
    spi_ee_asserts #(.EN_WAIT(20), .RD_WAIT(10)) spi_ee_asserts_inst (.CLK_SYS(clk_sys),
        .RST_N(rst_n), .en(link.en), .sclk(link.sclk), .din(link.din), .dout(link.dout));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Wire bits are taken at shift clock rises, midway through each bit.
    always @(posedge clk_sys) begin
        sclk_q <= link.sclk;
        if (mem_req2 === 1'b1) n_req2 <= n_req2 + 1;
        if (!link.en) n_rise <= 7'h00;
        else if (!sclk_q && link.sclk) begin
            n_rise <= n_rise + 7'h01;
            rd_word <= {rd_word[30:0], link.dout};
            if (n_rise < 48) wire_frame <= {wire_frame[46:0], link.din};
        end
    end
    initial forever begin
        @(posedge clk_sys);
        #1;
        if (mem_req === 1'b1) begin
            n_req++;
            repeat (40) begin
                @(posedge clk_sys);
                #1 if (link.dout === 1'b1) early++;
            end
            mem_done = 1'b1;
            @(posedge clk_sys);
            #1 mem_done = 1'b0;
        end
    end
    task automatic chk(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_op(input logic [7:0] c, input logic [31:0] d);
        int r0;
        int k;
        r0 = n_req;
        k = 0;
        cmd = c;
        addr = d[15:8];
        wdata = d;
        mem_rdata = ~d;
        start = 1'b1;
        @(posedge clk_sys);
        #1 start = 1'b0;
        chk(busy === 1'b1, "busy not raised");
        while (done !== 1'b1 && k < 20000) begin
            @(posedge clk_sys);
            #1 k++;
        end
        chk(k < 20000, "no done");
        chk(busy === 1'b0, "busy after done");
        chk(n_req == r0 + 1, "request count");
        chk(mem_cmd === c, "command byte");
        chk(mem_addr === d[15:8] && mem_wdata === d, "address or data");
        chk(wire_frame === {c, d[15:8], d}, "frame on the wire");
        chk(comm_err === 1'b0, "error flag");
        chk(early == 0, "completion before memory");
        if (c[6]) chk(rdata === ~d && rd_word === ~d, "read word");
        $display("op %h finished", c);
    endtask
    // The hand-driven shift clock is unrelated in phase to clk_sys.
    task automatic t_rogue(input int n);
        int r0;
        r0 = n_req2;
        link2.en = 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        for (int i = 0; i < n; i++) begin
            link2.din = i[0] ^ i[2];
            #62.5 link2.sclk = 1'b1;
            #62.5 link2.sclk = 1'b0;
        end
        #2000 link2.en = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        if (n < 48) chk(n_req2 == r0, "partial frame ran");
        else chk(comm_err2 === 1'b1, "no error for extra pulses");
        $display("hand frame of %0d pulses finished", n);
    endtask
    initial begin
        {rst_n, start, mem_done, cmd, addr, wdata, mem_rdata} = '0;
        {link2.en, link2.sclk, link2.din} = 3'h0;
        {n_req, n_req2, early, n_mismatch, n_checks} = '0;
        repeat (5) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        for (int i = 2; i < 8; i++) begin
            t_op(8'(1 << i) | 8'(i % 2), 32'h8000_0001 ^ 32'(i * 32'h0101_0101));
        end
        t_op(8'h41, 32'h0F0F_A5C3);
        t_rogue(20);
        t_rogue(50);
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
